// ### hdl/line_blockage_diagnosis_pkg.sv
// Shared constants and types of the impulse line blockage diagnostic
package iplbd_pkg;

	// ****************************************
	// Detection mode codes
	// ****************************************
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_CALC = 2'h1;
	localparam logic [1:0] MODE_REF  = 2'h2;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_CALC = 3'b010,
		ST_REF  = 3'b100
	} iplbd_state_t;

	// ****************************************
	// Result word bit positions
	// ****************************************
	localparam int unsigned BIT_A_BLK    = 2;
	localparam int unsigned BIT_LO_LARGE = 3;
	localparam int unsigned BIT_HI_LARGE = 4;
	localparam int unsigned BIT_LO_BLK   = 5;
	localparam int unsigned BIT_HI_BLK   = 6;
	localparam int unsigned BIT_B_BLK    = 7;
	localparam int unsigned BIT_INV_BLKF = 8;
	localparam int unsigned BIT_INV_FSPH = 9;
	localparam int unsigned BIT_INV_FSPL = 10;
	localparam int unsigned BIT_INV_FDP  = 11;
	localparam int unsigned BIT_RANGE    = 12;
	localparam logic [15:0] RESULT_RST   = 16'h0000;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [15:0] PERIOD_MIN = 16'h0014;
	localparam logic [15:0] PERIOD_DEF = 16'h00b4;
	localparam logic [7:0]  COUNT_DEF  = 8'h03;
	localparam int unsigned THR_NUM    = 10;
	// Ratio thresholds are unsigned Q8.8, the last four entries signed Q1.14
	localparam logic [15:0] THR_DEF [THR_NUM] = '{
		16'h0180, 16'h00c0, 16'h0180, 16'h00c0, 16'h0180,
		16'h00c0, 16'h1000, 16'hf000, 16'h3000, 16'hd000
	};
	localparam logic [15:0] FDP_MIN    = 16'h0007;
	localparam logic [15:0] FSP_MIN    = 16'h0001;
	localparam logic [15:0] BLKF_LO    = 16'he000;
	localparam logic [15:0] BLKF_HI    = 16'h2000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned SECOND_NS     = 1_000_000_000;
	localparam int unsigned CLK_PERIOD_NS = 4;

endpackage

// ### hdl/line_blockage_diagnosis_diag.sv
// Impulse line blockage diagnostic controller
//
// How it works
// - Reference window lasts the acquisition period
// - Reference request starts the window at once
// - Window end: go calculate, stamp time
// - New capture overwrites the single stored baseline
// - Power loss returns to stop; rerequest
// - Capture stores five baseline values
// - Weak baseline sets invalid flag, skips checks
// - Invalid baselines still leave calculation running
// - Out-of-service capture flags invalid baselines
// - Flag only after consecutive-count detections
// - Differential ratio against elements one, two
// - Low side checks use three, four, eight
// - High side checks use five, six, seven
// - Period accepts 20 to 65535 seconds
// - Mean dp outside nine/ten flags range
// - Mode codes: stop 0, calc 1, reference 2
// - Result word bit positions fixed
`timescale 1ns/1ps
`default_nettype none

module iplbd_diag #(
	parameter int unsigned CYC_PER_SEC = iplbd_pkg::SECOND_NS / iplbd_pkg::CLK_PERIOD_NS,
	parameter int unsigned CNT_W       = 8
) (
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	input  wire logic              mode_wr_i,
	input  wire logic [1:0]        mode_wdata_i,
	input  wire logic              period_wr_i,
	input  wire logic [15:0]       period_wdata_i,
	input  wire logic              count_wr_i,
	input  wire logic [CNT_W-1:0]  count_wdata_i,
	input  wire logic              thr_wr_i,
	input  wire logic [3:0]        thr_idx_i,
	input  wire logic [15:0]       thr_wdata_i,
	input  wire logic              out_of_service_i,
	input  wire logic [15:0]       fdp_i,
	input  wire logic [15:0]       fspl_i,
	input  wire logic [15:0]       fsph_i,
	input  wire logic [15:0]       blkf_i,
	input  wire logic [15:0]       dpavg_i,
	input  wire logic [31:0]       time_now_i,
	output logic [1:0]             mode_o,
	output logic [15:0]            period_o,
	output logic [CNT_W-1:0]       count_o,
	output logic [15:0]            result_o,
	output logic [15:0]            ref_fdp_o,
	output logic [15:0]            ref_fspl_o,
	output logic [15:0]            ref_fsph_o,
	output logic [15:0]            ref_blkf_o,
	output logic [15:0]            ref_dpavg_o,
	output logic [31:0]            ref_time_o,
	output logic                   period_end_o
);
	import iplbd_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (CYC_PER_SEC < 1 || CNT_W < 2 || CNT_W > 16) begin : g_bad_param
		$error("CYC_PER_SEC must be at least one and CNT_W lie in 2..16");
	end

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	// sqrt(cur/ref) against a Q8.8 threshold, squared to avoid root and divide
	function automatic logic [1:0] ratio_cmp(input logic [15:0] cur,
			input logic [15:0] ref_v, input logic [15:0] thr);
		logic [47:0] lhs;
		logic [47:0] rhs;
		lhs = {16'h0000, cur, 16'h0000};
		rhs = 48'(thr) * 48'(thr) * 48'(ref_v);
		return {lhs > rhs, lhs < rhs};
	endfunction
	function automatic logic out_of_window(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		return ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
	endfunction

	// ****************************************
	// State
	// ****************************************
	iplbd_state_t     state;
	iplbd_state_t     next_state;
	logic [31:0]      cyc;
	logic [15:0]      sec;
	logic [15:0]      thr [THR_NUM];
	logic [CNT_W-1:0] cnt [6];

	wire sec_end    = (cyc == CYC_PER_SEC - 1);
	wire win_end    = sec_end && (sec == period_o - 16'h0001);
	wire in_stop    = (state == ST_STOP);
	wire mode_ok    = mode_wr_i && (mode_wdata_i != 2'h3);
	wire req_ref    = mode_ok && (mode_wdata_i == MODE_REF);
	wire thr_ok     = thr_wr_i && in_stop && thr_idx_i >= 4'h1 && thr_idx_i <= 4'ha;
	wire period_ok  = period_wr_i && in_stop && (period_wdata_i >= PERIOD_MIN);
	wire count_ok   = count_wr_i && in_stop && (count_wdata_i != '0);

	// ****************************************
	// Mode machine
	// ****************************************
	always_comb begin
		next_state = state;
		if (mode_ok) begin
			unique case (mode_wdata_i)
				MODE_STOP: next_state = ST_STOP;
				MODE_CALC: next_state = ST_CALC;
				default:   next_state = ST_REF;
			endcase
		end else if (state == ST_REF && win_end) begin
			next_state = ST_CALC;
		end
	end

	wire [1:0] next_mode = (next_state == ST_REF)  ? MODE_REF :
			(next_state == ST_CALC) ? MODE_CALC : MODE_STOP;

	// ****************************************
	// Reference validity and detection
	// ****************************************
	// The range test also judges the baseline mean dp at capture time
	wire       range_bad = out_of_window(dpavg_i, thr[9], thr[8]);
	wire       inv_blkf  = out_of_service_i || range_bad
			|| out_of_window(blkf_i, BLKF_LO, BLKF_HI);
	wire       inv_fsph  = out_of_service_i || range_bad || (fsph_i < FSP_MIN);
	wire       inv_fspl  = out_of_service_i || (fspl_i < FSP_MIN);
	wire       inv_fdp   = out_of_service_i || range_bad || (fdp_i < FDP_MIN);
	wire       fdp_ok    = !result_o[BIT_INV_FDP] && !range_bad;
	wire       fspl_ok   = fdp_ok && !result_o[BIT_INV_FSPL];
	wire       fsph_ok   = fdp_ok && !result_o[BIT_INV_FSPH];
	wire       blkf_ok   = fdp_ok && !result_o[BIT_INV_BLKF];
	wire [1:0] c_fdp1    = ratio_cmp(fdp_i, ref_fdp_o, thr[0]);
	wire [1:0] c_fdp2    = ratio_cmp(fdp_i, ref_fdp_o, thr[1]);
	wire [1:0] c_fspl3   = ratio_cmp(fspl_i, ref_fspl_o, thr[2]);
	wire [1:0] c_fspl4   = ratio_cmp(fspl_i, ref_fspl_o, thr[3]);
	wire [1:0] c_fsph5   = ratio_cmp(fsph_i, ref_fsph_o, thr[4]);
	wire [1:0] c_fsph6   = ratio_cmp(fsph_i, ref_fsph_o, thr[5]);
	wire       blkf_hi   = $signed(blkf_i) > $signed(thr[6]);
	wire       blkf_lo   = $signed(blkf_i) < $signed(thr[7]);
	// Order matches result bits 2..7
	wire [5:0] det = {
		fdp_ok && c_fdp2[0],
		(fsph_ok && c_fsph6[0]) || (blkf_ok && blkf_hi),
		(fspl_ok && c_fspl4[0]) || (blkf_ok && blkf_lo),
		fsph_ok && c_fsph5[1],
		fspl_ok && c_fspl3[1],
		fdp_ok && c_fdp1[1]
	};

	// ****************************************
	// Timebase
	// ****************************************
	// Restarted by every mode change so each window is a full period
	always_ff @(posedge clock_i) begin
		if (!rstn_i || (ce_i && (mode_ok || in_stop))) begin
			cyc <= '0;
			sec <= '0;
		end else if (ce_i) begin
			cyc <= sec_end ? '0 : cyc + 32'h0000_0001;
			if (win_end) begin
				sec <= '0;
			end else if (sec_end) begin
				sec <= sec + 16'h0001;
			end
		end
	end

	// ****************************************
	// Control, configuration and results
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state        <= ST_STOP;
			mode_o       <= MODE_STOP;
			period_o     <= PERIOD_DEF;
			count_o      <= CNT_W'(COUNT_DEF);
			result_o     <= RESULT_RST;
			ref_fdp_o    <= '0;
			ref_fspl_o   <= '0;
			ref_fsph_o   <= '0;
			ref_blkf_o   <= '0;
			ref_dpavg_o  <= '0;
			ref_time_o   <= '0;
			period_end_o <= 1'b0;
			for (int i = 0; i < THR_NUM; i++) begin
				thr[i] <= THR_DEF[i];
			end
			for (int i = 0; i < 6; i++) begin
				cnt[i] <= '0;
			end
		end else if (ce_i) begin
			state        <= next_state;
			mode_o       <= next_mode;
			period_end_o <= win_end && !in_stop && !mode_ok;
			if (period_ok) begin
				period_o <= period_wdata_i;
			end
			if (count_ok) begin
				count_o <= count_wdata_i;
			end
			if (thr_ok) begin
				thr[thr_idx_i - 4'h1] <= thr_wdata_i;
			end
			if (next_state == ST_STOP || req_ref) begin
				for (int i = 0; i < 6; i++) begin
					cnt[i] <= '0;
				end
				result_o[BIT_B_BLK:BIT_A_BLK] <= '0;
			end else if (state == ST_REF && win_end) begin
				ref_fdp_o   <= fdp_i;
				ref_fspl_o  <= fspl_i;
				ref_fsph_o  <= fsph_i;
				ref_blkf_o  <= blkf_i;
				ref_dpavg_o <= dpavg_i;
				ref_time_o  <= time_now_i;
				result_o[BIT_INV_FDP:BIT_INV_BLKF] <=
						{inv_fdp, inv_fspl, inv_fsph, inv_blkf};
			end else if (state == ST_CALC && win_end) begin
				for (int i = 0; i < 6; i++) begin
					if (det[i]) begin
						cnt[i] <= (&cnt[i]) ? cnt[i] : cnt[i] + CNT_W'(1);
						result_o[BIT_A_BLK + i] <= (&cnt[i]) || (cnt[i] + CNT_W'(1) >= count_o);
					end else begin
						cnt[i] <= '0;
						result_o[BIT_A_BLK + i] <= 1'b0;
					end
				end
			end
			if (state == ST_CALC) begin
				result_o[BIT_RANGE] <= range_bad;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence s_window_end;
		ce_i && state == ST_REF && win_end && !mode_ok;
	endsequence
	sequence s_ref_req;
		ce_i && req_ref;
	endsequence
	property p_ref_start;
		s_ref_req |=> state == ST_REF && mode_o == MODE_REF && sec == 16'h0000;
	endproperty
	a_ref_start: assert property (p_ref_start) else $error("reference not started");
	property p_ref_done;
		s_window_end |=> mode_o == MODE_CALC && ref_time_o == $past(time_now_i)
				&& ref_fdp_o == $past(fdp_i) && ref_dpavg_o == $past(dpavg_i);
	endproperty
	a_ref_done: assert property (p_ref_done) else $error("reference end wrong");
	property p_invalid_keeps_calc;
		s_window_end ##1 (result_o[11:8] != 4'h0) |-> state == ST_CALC;
	endproperty
	a_invalid_keeps_calc: assert property (p_invalid_keeps_calc) else $error("left calc");
	property p_oos_invalid;
		s_window_end and out_of_service_i |=> result_o[11:8] == 4'hf;
	endproperty
	a_oos_invalid: assert property (p_oos_invalid) else $error("oos not flagged");
	property p_reset_stop;
		@(posedge clock_i) disable iff (1'b0) !rstn_i |=> mode_o == MODE_STOP;
	endproperty
	a_reset_stop: assert property (p_reset_stop) else $error("reset not stop");
	property p_period_range;
		period_o >= PERIOD_MIN;
	endproperty
	a_period_range: assert property (p_period_range) else $error("period too short");
	property p_flag_count;
		$rose(result_o[BIT_LO_BLK]) |-> cnt[3] >= count_o;
	endproperty
	a_flag_count: assert property (p_flag_count) else $error("flag early");
	property p_stop_clears;
		state == ST_STOP ##1 state == ST_STOP |-> cnt[0] == '0 && cnt[5] == '0;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("counter kept");
	property p_range_flag;
		ce_i && state == ST_CALC && range_bad |=> result_o[BIT_RANGE];
	endproperty
	a_range_flag: assert property (p_range_flag) else $error("range not flagged");
	property p_fdp_skip;
		state == ST_CALC && $past(state == ST_CALC) && result_o[BIT_INV_FDP]
				|-> result_o[BIT_B_BLK:BIT_A_BLK] == '0;
	endproperty
	a_fdp_skip: assert property (p_fdp_skip) else $error("check not skipped");

endmodule

`default_nettype wire

// ### dv/line_blockage_diagnosis_host.sv
// Host model that writes the diagnostic's configuration parameters
`timescale 1ns/1ps
`default_nettype none

module iplbd_host (
	input  wire logic        clock_i,
	output logic             mode_wr_o,
	output logic [1:0]       mode_wdata_o,
	output logic             period_wr_o,
	output logic [15:0]      period_wdata_o,
	output logic             count_wr_o,
	output logic [7:0]       count_wdata_o,
	output logic             thr_wr_o,
	output logic [3:0]       thr_idx_o,
	output logic [15:0]      thr_wdata_o
);
	initial begin
		{mode_wr_o, period_wr_o, count_wr_o, thr_wr_o} = 4'h0;
		{mode_wdata_o, period_wdata_o, count_wdata_o, thr_idx_o, thr_wdata_o} = '0;
	end

	// ****************************************
	// One write: kind 0 mode, 1 period, 2 count, 3 threshold
	// ****************************************
	// Data is inverted once the strobe drops so a late sample never sees a stale match
	task automatic wr(input int kind, input logic [3:0] idx, input logic [15:0] d);
		@(posedge clock_i);
		#1;
		{mode_wdata_o, period_wdata_o, count_wdata_o} = {d[1:0], d, d[7:0]};
		{thr_idx_o, thr_wdata_o} = {idx, d};
		{mode_wr_o, period_wr_o, count_wr_o, thr_wr_o} = {kind == 0, kind == 1, kind == 2, kind == 3};
		@(posedge clock_i);
		#1;
		{mode_wr_o, period_wr_o, count_wr_o, thr_wr_o} = 4'h0;
		{mode_wdata_o, period_wdata_o, count_wdata_o} = {~d[1:0], ~d, ~d[7:0]};
		{thr_idx_o, thr_wdata_o} = {~idx, ~d};
	endtask
endmodule

`default_nettype wire

// ### dv/tb_impulse_line_blockage_diag.sv
// Self-checking bench of the impulse line blockage diagnostic
`timescale 1ns/1ps
`default_nettype none

module tb_impulse_line_blockage_diag;
	import iplbd_pkg::*;
	localparam int unsigned CPS = 4;
	localparam logic [79:0] NOM = {16'h03e8, 16'h03e8, 16'h03e8, 16'h0000, 16'h0000};
	// Row: fdp, fspl, fsph, blkf, dpavg, expected result word
	localparam logic [95:0] ROWS [11] = '{
		{NOM, 16'h0000},
		{16'h0064, NOM[63:0], 16'h0080},
		{16'h0fa0, NOM[63:0], 16'h0004},
		{16'h03e8, 16'h0fa0, NOM[47:0], 16'h0008},
		{16'h03e8, 16'h0064, NOM[47:0], 16'h0020},
		{NOM[79:48], 16'h0fa0, NOM[31:0], 16'h0010},
		{NOM[79:48], 16'h0064, NOM[31:0], 16'h0040},
		{NOM[79:32], 16'h1800, 16'h0000, 16'h0040},
		{NOM[79:32], 16'he800, 16'h0000, 16'h0020},
		{NOM[79:16], 16'h3800, 16'h1000},
		{NOM[79:16], 16'hc800, 16'h1000}
	};
	logic        clock_i;
	logic        rstn_i;
	logic        out_of_service;
	logic        ce;
	logic [15:0] fdp, fspl, fsph, blkf, dpavg;
	logic [31:0] tnow;
	wire logic   mode_wr, period_wr, count_wr, thr_wr;
	wire logic [1:0]  mode_wd;
	wire logic [15:0] period_wd, thr_wd;
	wire logic [7:0]  count_wd;
	wire logic [3:0]  thr_idx;
	logic [1:0]  mode_o;
	logic [15:0] period_o, result_o, ref_fdp_o, ref_fspl_o, ref_fsph_o, ref_blkf_o, ref_dpavg_o;
	logic [7:0]  count_o;
	logic [31:0] ref_time_o;
	logic        period_end_o;
	int          n_mismatch = 0;
	int          checked = 0;

	iplbd_diag #(.CYC_PER_SEC(CPS), .CNT_W(8)) dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
		.mode_wr_i(mode_wr), .mode_wdata_i(mode_wd), .period_wr_i(period_wr),
		.period_wdata_i(period_wd), .count_wr_i(count_wr), .count_wdata_i(count_wd),
		.thr_wr_i(thr_wr), .thr_idx_i(thr_idx), .thr_wdata_i(thr_wd),
		.out_of_service_i(out_of_service), .fdp_i(fdp), .fspl_i(fspl), .fsph_i(fsph),
		.blkf_i(blkf), .dpavg_i(dpavg), .time_now_i(tnow), .mode_o(mode_o),
		.period_o(period_o), .count_o(count_o), .result_o(result_o),
		.ref_fdp_o(ref_fdp_o), .ref_fspl_o(ref_fspl_o), .ref_fsph_o(ref_fsph_o),
		.ref_blkf_o(ref_blkf_o), .ref_dpavg_o(ref_dpavg_o), .ref_time_o(ref_time_o),
		.period_end_o(period_end_o));

	iplbd_host host (
		.clock_i(clock_i), .mode_wr_o(mode_wr), .mode_wdata_o(mode_wd),
		.period_wr_o(period_wr), .period_wdata_o(period_wd), .count_wr_o(count_wr),
		.count_wdata_o(count_wd), .thr_wr_o(thr_wr), .thr_idx_o(thr_idx),
		.thr_wdata_o(thr_wd));

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude();
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask

	task automatic timeout();
		n_mismatch++;
		conclude();
	endtask

	task automatic set_in(input logic [79:0] v);
		{fdp, fspl, fsph, blkf, dpavg} = v;
	endtask

	// Returns two cycles after the n-th period-end pulse so the flags have landed
	task automatic wait_pe(input int n);
		int k;
		int j;
		for (k = 0; k < n; k++) begin
			j = 0;
			do begin
				tick();
				j++;
				if (j > 200) timeout();
			end while (period_end_o !== 1'b1);
		end
		tick();
		tick();
	endtask

	// Window is 20 s at CPS cycles a second, about 80 cycles
	task automatic capture(input logic [15:0] f, input logic o, input logic [31:0] t);
		int i;
		set_in(NOM);
		fdp = f;
		out_of_service = o;
		tnow = t;
		host.wr(0, 4'h0, 16'h0002);
		chk("refmode", MODE_REF, mode_o);
		i = 0;
		while (mode_o !== MODE_CALC) begin
			tick();
			i++;
			if (i > 200) timeout();
		end
		chk("reflen", 1, i >= 76 && i <= 84);
		chk("reffdp", f, ref_fdp_o);
		chk("reftime", t, ref_time_o);
		out_of_service = 1'b0;
		tnow = ~t;
		tick();
		tick();
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		rstn_i = 1'b0;
		out_of_service = 1'b0;
		ce = 1'b1;
		tnow = 32'h0000_0000;
		set_in(NOM);
		repeat (3) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		chk("mode", MODE_STOP, mode_o);
		chk("period", PERIOD_DEF, period_o);
		chk("count", COUNT_DEF, count_o);
		chk("result", RESULT_RST, result_o);
		host.wr(0, 4'h0, 16'h0003);
		host.wr(1, 4'h0, 16'h0013);
		host.wr(2, 4'h0, 16'h0000);
		chk("mode3", MODE_STOP, mode_o);
		chk("per19", PERIOD_DEF, period_o);
		chk("cnt0", COUNT_DEF, count_o);
		host.wr(1, 4'h0, 16'hffff);
		chk("permax", 16'hffff, period_o);
		host.wr(1, 4'h0, PERIOD_MIN);
		host.wr(2, 4'h0, 16'h0001);
		chk("permin", PERIOD_MIN, period_o);
		capture(16'h03e8, 1'b0, 32'h1111_0000);
		chk("basefsp", NOM[63:32], {ref_fspl_o, ref_fsph_o});
		chk("baseblk", NOM[31:0], {ref_blkf_o, ref_dpavg_o});
		chk("clean", 16'h0000, result_o);
		for (int r = 0; r < 11; r++) begin
			set_in(ROWS[r][95:16]);
			wait_pe(2);
			chk("row", ROWS[r][15:0], result_o);
		end
		set_in(NOM);
		host.wr(1, 4'h0, 16'h0032);
		chk("percalc", PERIOD_MIN, period_o);
		capture(16'h0003, 1'b0, 32'h2222_0000);
		chk("invfdp", 16'h0800, result_o & 16'h0f00);
		chk("keep", MODE_CALC, mode_o);
		fdp = 16'h0064;
		wait_pe(2);
		chk("skip", 16'h0000, result_o & 16'h00fc);
		capture(16'h03e8, 1'b1, 32'h3333_0000);
		chk("oosinv", 1, (result_o & 16'h0f00) != 16'h0000);
		chk("oosmode", MODE_CALC, mode_o);
		host.wr(0, 4'h0, 16'h0000);
		host.wr(2, 4'h0, 16'h0003);
		capture(16'h03e8, 1'b0, 32'h4444_0000);
		fdp = 16'h0064;
		wait_pe(2);
		chk("b2", 0, result_o[BIT_B_BLK]);
		wait_pe(1);
		chk("b3", 1, result_o[BIT_B_BLK]);
		fdp = 16'h03e8;
		wait_pe(1);
		chk("miss", 0, result_o[BIT_B_BLK]);
		fdp = 16'h0064;
		wait_pe(1);
		chk("recount", 0, result_o[BIT_B_BLK]);
		wait_pe(2);
		chk("b3b", 1, result_o[BIT_B_BLK]);
		host.wr(0, 4'h0, 16'h0000);
		tick();
		chk("stopclr", 0, result_o & 16'h00fc);
		host.wr(2, 4'h0, 16'h0001);
		host.wr(3, 4'h2, 16'h0040);
		host.wr(0, 4'h0, 16'h0001);
		wait_pe(2);
		chk("thr2", 0, result_o[BIT_B_BLK]);
		host.wr(0, 4'h0, 16'h0002);
		repeat (10) tick();
		rstn_i = 1'b0;
		tick();
		rstn_i = 1'b1;
		chk("pwrloss", MODE_STOP, mode_o);
		host.wr(1, 4'h0, PERIOD_MIN);
		capture(16'h03e8, 1'b0, 32'h5555_0000);
		// A stop written while the enable is low must be lost
		ce = 1'b0;
		host.wr(0, 4'h0, 16'h0000);
		repeat (100) tick();
		chk("cefreeze", MODE_CALC, mode_o);
		ce = 1'b1;
		tick();
		chk("cerun", MODE_CALC, mode_o);
		conclude();
	end
endmodule

`default_nettype wire
